/* File: hdl/hbd_map.svh */
// Register offsets, field values, reset values and timing figures of the brake block.
// Assumes inclusion by bare name from the package and the modules that need them.
`ifndef HBD_MAP_SVH
`define HBD_MAP_SVH

`define HBD_ADDR_W            12
`define HBD_OFS_RELEASE_DLY   12'h50E
`define HBD_OFS_APPLY_DLY     12'h510
`define HBD_OFS_ROT_DIR       12'h618
`define HBD_RST_RELEASE_DLY   16'h0000
`define HBD_RST_APPLY_DLY     16'h0000
`define HBD_RST_ROT_DIR       16'h0000
`define HBD_DLY_MAX_MS        16'h03E8
`define HBD_DIR_CW            16'h0000
`define HBD_DIR_CCW           16'h0001
`define HBD_DIR_BIT           0
`define HBD_MS_ONE            16'h0001
`define HBD_MS_ZERO           16'h0000

`endif

/* File: hdl/hbd_pkg.sv */
// Types shared by the holding brake and direction control block.
// Assumes the map header sits beside it on the include path.
`include "hbd_map.svh"

package hbd_pkg;

  typedef enum logic [2:0]
  {
    HBD_ST_OFF      = 3'b000,
    HBD_ST_ENERGISE = 3'b001,
    HBD_ST_RELEASE  = 3'b010,
    HBD_ST_RUN      = 3'b011,
    HBD_ST_APPLY    = 3'b100
  } hbd_state_e;

  typedef struct packed
  {
    logic [15:0] release_dly;
    logic [15:0] apply_dly;
    logic [15:0] rot_dir;
  } hbd_settings_s;

  typedef struct packed
  {
    logic                  wr;
    logic                  rd;
    logic [`HBD_ADDR_W-1:0] addr;
    logic [15:0]           wdata;
  } hbd_par_req_s;

endpackage : hbd_pkg

/* File: hdl/hbd_ms_timer.sv */
// Millisecond delay timer for the brake sequencer.
// Assumes ms_tick is a one-cycle pulse on sys_clk once per millisecond.
`include "hbd_map.svh"

module hbd_ms_timer
  import hbd_pkg::*;
#(
  parameter int unsigned CNT_W = 16
)
(
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire logic             ms_tick,
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] load_ms,
  output logic                  expired_q
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             run_q;
  logic             run_d;
  logic             expired_d;

  always_comb
  begin
    cnt_d     = cnt_q;
    run_d     = run_q;
    expired_d = 1'b0;
    if (start)
    begin
      // Restart wins over a pending expiry, so a stale timeout never leaks out
      cnt_d = load_ms;
      run_d = 1'b1;
    end
    else if (run_q && ms_tick)
    begin
      cnt_d = cnt_q - CNT_W'(`HBD_MS_ONE);
      if (cnt_q == CNT_W'(`HBD_MS_ONE))
      begin
        run_d     = 1'b0;
        expired_d = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cnt_q     <= '0;
      run_q     <= 1'b0;
      expired_q <= 1'b0;
    end
    else if (clk_en)
    begin
      cnt_q     <= cnt_d;
      run_q     <= run_d;
      expired_q <= expired_d;
    end
  end

endmodule : hbd_ms_timer

/* File: hdl/hbd_top.sv */
// Holding brake release sequencing and rotation direction control.
// Assumes settings are restored from non-volatile storage by one pulse after reset.
// How it works
// - Brake release output rises once power stage is on and holding torque exists.
// - Release output high means brake released or releasing, low means engaged.
// - Motion response to enable waits the release delay after the brake output rises.
// - Release delay: 16-bit milliseconds, 0 to 1000, default 0, persistent.
// - Withdrawing enable drops the brake release output at once.
// - Motor stays energised for the apply delay after the brake output falls.
// - Apply delay: 16-bit milliseconds, 0 to 1000, default 0, persistent.
// - Direction value 0 is clockwise, 1 counter-clockwise; 16-bit, persistent, default 0.
// - A new direction takes effect only at the next power-up.
// - Clockwise setting turns shaft clockwise for positive speed commands.
// - Positive limit bounds clockwise travel, negative limit bounds anti-clockwise travel.
// - Reversed direction negates encoder absolute position and evaluated actual position.
`include "hbd_map.svh"

module hbd_top
  import hbd_pkg::*;
#(
  parameter int unsigned POS_W = 32,
  parameter int unsigned SPD_W = 16
)
(
  input  wire logic                    sys_clk,
  input  wire logic                    sys_rst,
  input  wire logic                    clk_en,
  input  wire logic                    ms_tick,
  input  wire logic                    enable_cmd,
  input  wire logic                    holding_torque_ok,
  input  wire logic                    nv_restore,
  input  wire hbd_settings_s           nv_settings,
  input  wire hbd_par_req_s            par_req,
  input  wire logic                    positive_limit_in_n,
  input  wire logic                    negative_limit_in_n,
  input  wire logic signed [SPD_W-1:0] speed_cmd,
  input  wire logic signed [POS_W-1:0] enc_abs_pos,
  input  wire logic signed [POS_W-1:0] eval_act_pos,
  output logic                         brake_release_out_q,
  output logic                         power_stage_en_q,
  output logic                         motion_enable_q,
  output logic                         ready_q,
  output logic                         par_ack_q,
  output logic                         par_err_q,
  output logic [15:0]                  par_rdata_q,
  output hbd_settings_s                settings_q,
  output logic                         dir_ccw_active_q,
  output logic signed [SPD_W-1:0]      motor_speed_q,
  output logic signed [POS_W-1:0]      abs_pos_q,
  output logic signed [POS_W-1:0]      act_pos_q,
  output logic                         cw_limit_hit_q,
  output logic                         ccw_limit_hit_q
);

  // Limit pin synchroniser and agreement filter
  logic [1:0] pin_raw;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [1:0] sync3_q;
  logic [1:0] pin_lvl_q;
  logic [1:0] pin_lvl_d;

  assign pin_raw = {negative_limit_in_n, positive_limit_in_n};

  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_pin
      always_comb
      begin
        pin_lvl_d[i] = pin_lvl_q[i];
        if (sync2_q[i] == sync3_q[i])
        begin
          pin_lvl_d[i] = sync3_q[i];
        end
      end

      // Switches are open when idle: reset to released pins, no false limit
      always_ff @(posedge sys_clk)
      begin
        if (sys_rst)
        begin
          sync1_q[i]   <= 1'b1;
          sync2_q[i]   <= 1'b1;
          sync3_q[i]   <= 1'b1;
          pin_lvl_q[i] <= 1'b1;
        end
        else if (clk_en)
        begin
          sync1_q[i]   <= pin_raw[i];
          sync2_q[i]   <= sync1_q[i];
          sync3_q[i]   <= sync2_q[i];
          pin_lvl_q[i] <= pin_lvl_d[i];
        end
      end
    end
  endgenerate

  // Parameter access and persistent settings
  hbd_settings_s settings_d;
  logic          dir_act_d;
  logic          ready_d;
  logic          ack_d;
  logic          err_d;
  logic [15:0]   rdata_d;
  logic          in_range;
  logic          hit;

  always_comb
  begin
    settings_d = settings_q;
    dir_act_d  = dir_ccw_active_q;
    ready_d    = ready_q;
    ack_d      = 1'b0;
    err_d      = 1'b0;
    rdata_d    = par_rdata_q;
    in_range   = 1'b1;
    hit        = 1'b1;
    if (!ready_q)
    begin
      if (nv_restore)
      begin
        settings_d = nv_settings;
        // Direction is sampled only here; later writes wait for the next power-up
        dir_act_d  = nv_settings.rot_dir[`HBD_DIR_BIT];
        ready_d    = 1'b1;
      end
    end
    else if (par_req.wr || par_req.rd)
    begin
      ack_d = 1'b1;
      unique case (par_req.addr)
        `HBD_OFS_RELEASE_DLY:
        begin
          in_range = (par_req.wdata <= `HBD_DLY_MAX_MS);
          rdata_d  = settings_q.release_dly;
          if (par_req.wr && in_range)
          begin
            settings_d.release_dly = par_req.wdata;
          end
        end
        `HBD_OFS_APPLY_DLY:
        begin
          in_range = (par_req.wdata <= `HBD_DLY_MAX_MS);
          rdata_d  = settings_q.apply_dly;
          if (par_req.wr && in_range)
          begin
            settings_d.apply_dly = par_req.wdata;
          end
        end
        `HBD_OFS_ROT_DIR:
        begin
          in_range = (par_req.wdata <= `HBD_DIR_CCW);
          rdata_d  = settings_q.rot_dir;
          if (par_req.wr && in_range)
          begin
            settings_d.rot_dir = par_req.wdata;
          end
        end
        default:
        begin
          hit     = 1'b0;
          rdata_d = 16'h0000;
        end
      endcase
      err_d = !hit || (par_req.wr && !in_range);
      if (!par_req.wr)
      begin
        err_d = !hit;
      end
      if (par_req.wr)
      begin
        rdata_d = 16'h0000;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      settings_q       <= '{`HBD_RST_RELEASE_DLY, `HBD_RST_APPLY_DLY, `HBD_RST_ROT_DIR};
      dir_ccw_active_q <= 1'b0;
      ready_q          <= 1'b0;
      par_ack_q        <= 1'b0;
      par_err_q        <= 1'b0;
      par_rdata_q      <= 16'h0000;
    end
    else if (clk_en)
    begin
      settings_q       <= settings_d;
      dir_ccw_active_q <= dir_act_d;
      ready_q          <= ready_d;
      par_ack_q        <= ack_d;
      par_err_q        <= err_d;
      par_rdata_q      <= rdata_d;
    end
  end

  // Brake sequencer
  hbd_state_e state_q;
  hbd_state_e state_d;
  logic       tmr_start;
  logic [15:0] tmr_load;
  logic       tmr_expired;

  hbd_ms_timer #(
    .CNT_W (16)
  ) u_timer (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .ms_tick   (ms_tick),
    .start     (tmr_start),
    .load_ms   (tmr_load),
    .expired_q (tmr_expired)
  );

  always_comb
  begin
    state_d   = state_q;
    tmr_start = 1'b0;
    tmr_load  = settings_q.release_dly;
    unique case (state_q)
      HBD_ST_OFF:
      begin
        if (ready_q && enable_cmd)
        begin
          state_d = HBD_ST_ENERGISE;
        end
      end
      HBD_ST_ENERGISE:
      begin
        if (!enable_cmd)
        begin
          state_d = HBD_ST_OFF;
        end
        else if (holding_torque_ok)
        begin
          // Zero delay skips the wait state entirely
          if (settings_q.release_dly == `HBD_MS_ZERO)
          begin
            state_d = HBD_ST_RUN;
          end
          else
          begin
            state_d   = HBD_ST_RELEASE;
            tmr_start = 1'b1;
          end
        end
      end
      HBD_ST_RELEASE, HBD_ST_RUN:
      begin
        if (!enable_cmd)
        begin
          tmr_load = settings_q.apply_dly;
          if (settings_q.apply_dly == `HBD_MS_ZERO)
          begin
            state_d = HBD_ST_OFF;
          end
          else
          begin
            state_d   = HBD_ST_APPLY;
            tmr_start = 1'b1;
          end
        end
        else if (state_q == HBD_ST_RELEASE && tmr_expired)
        begin
          state_d = HBD_ST_RUN;
        end
      end
      HBD_ST_APPLY:
      begin
        // A new enable is held off until the motor is fully de-energised
        if (tmr_expired)
        begin
          state_d = HBD_ST_OFF;
        end
      end
      default:
      begin
        state_d = HBD_ST_OFF;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_q             <= HBD_ST_OFF;
      brake_release_out_q <= 1'b0;
      power_stage_en_q    <= 1'b0;
      motion_enable_q     <= 1'b0;
    end
    else if (clk_en)
    begin
      state_q             <= state_d;
      brake_release_out_q <= (state_d == HBD_ST_RELEASE) || (state_d == HBD_ST_RUN);
      power_stage_en_q    <= (state_d != HBD_ST_OFF);
      motion_enable_q     <= (state_d == HBD_ST_RUN);
    end
  end

  // Direction mapping of speed, position and limits
  logic signed [SPD_W-1:0] spd_motor;
  logic signed [SPD_W-1:0] speed_d;
  logic signed [POS_W-1:0] abs_d;
  logic signed [POS_W-1:0] act_d;
  logic                    cw_hit_d;
  logic                    ccw_hit_d;

  always_comb
  begin
    // Motor frame: positive is clockwise at the flange
    spd_motor = dir_ccw_active_q ? -speed_cmd : speed_cmd;
    cw_hit_d  = !pin_lvl_q[0];
    ccw_hit_d = !pin_lvl_q[1];
    speed_d   = spd_motor;
    if (!motion_enable_q || (cw_hit_d && spd_motor > 0) || (ccw_hit_d && spd_motor < 0))
    begin
      speed_d = '0;
    end
    abs_d = dir_ccw_active_q ? -enc_abs_pos : enc_abs_pos;
    act_d = dir_ccw_active_q ? -eval_act_pos : eval_act_pos;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      motor_speed_q   <= '0;
      abs_pos_q       <= '0;
      act_pos_q       <= '0;
      cw_limit_hit_q  <= 1'b0;
      ccw_limit_hit_q <= 1'b0;
    end
    else if (clk_en)
    begin
      motor_speed_q   <= speed_d;
      abs_pos_q       <= abs_d;
      act_pos_q       <= act_d;
      cw_limit_hit_q  <= cw_hit_d;
      ccw_limit_hit_q <= ccw_hit_d;
    end
  end

endmodule : hbd_top

/* File: testbench/hbd_checker.sv */
// Assertions on the brake sequencer and direction mapping ports.
// Assumes binding to hbd_top; sees only its ports.
`include "hbd_map.svh"

module hbd_checker
  import hbd_pkg::*;
#(
  parameter int unsigned POS_W = 32,
  parameter int unsigned SPD_W = 16
)
(
  input wire logic                    sys_clk,
  input wire logic                    sys_rst,
  input wire logic                    clk_en,
  input wire logic                    enable_cmd,
  input wire logic                    holding_torque_ok,
  input wire logic signed [POS_W-1:0] enc_abs_pos,
  input wire logic                    brake_release_out_q,
  input wire logic                    power_stage_en_q,
  input wire logic                    motion_enable_q,
  input wire logic                    ready_q,
  input wire hbd_settings_s           settings_q,
  input wire logic                    dir_ccw_active_q,
  input wire logic signed [SPD_W-1:0] motor_speed_q,
  input wire logic signed [POS_W-1:0] abs_pos_q,
  input wire logic                    cw_limit_hit_q,
  input wire logic                    ccw_limit_hit_q
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  a_brake_idle_low: assert property (!ready_q |-> !brake_release_out_q && !motion_enable_q)
    else $error("brake released before ready");
  a_brake_needs_torque: assert property ($rose(brake_release_out_q) |->
    $past(holding_torque_ok) && $past(power_stage_en_q))
    else $error("brake released without torque");
  a_motion_after_brake: assert property (motion_enable_q |-> brake_release_out_q)
    else $error("motion without released brake");
  a_disable_drops_brake: assert property (brake_release_out_q && !enable_cmd && clk_en
    |=> !brake_release_out_q && !motion_enable_q)
    else $error("brake held after disable");
  a_apply_keeps_power: assert property ($fell(brake_release_out_q) &&
    settings_q.apply_dly != 16'h0000 |-> power_stage_en_q)
    else $error("power dropped before apply delay");
  a_delay_in_range: assert property (settings_q.release_dly <= `HBD_DLY_MAX_MS &&
    settings_q.apply_dly <= `HBD_DLY_MAX_MS && settings_q.rot_dir <= 16'h0001)
    else $error("setting out of range");
  a_dir_fixed_run: assert property (ready_q && $past(ready_q) |-> $stable(dir_ccw_active_q))
    else $error("direction changed while running");
  a_pos_sense: assert property ($past(clk_en) && !$past(sys_rst) && !$past(sys_rst, 2) |->
    abs_pos_q == ($past(dir_ccw_active_q) ? -$past(enc_abs_pos) : $past(enc_abs_pos)))
    else $error("absolute position sense wrong");
  a_cw_limit_block: assert property (cw_limit_hit_q && $past(cw_limit_hit_q) |->
    (motor_speed_q[SPD_W-1] || motor_speed_q == '0))
    else $error("positive speed past clockwise limit");
  a_ccw_limit_block: assert property (ccw_limit_hit_q && $past(ccw_limit_hit_q) |->
    !motor_speed_q[SPD_W-1])
    else $error("negative speed past anti-clockwise limit");
endmodule : hbd_checker

bind hbd_top hbd_checker #(.POS_W(POS_W), .SPD_W(SPD_W)) u_hbd_checker
(
  .sys_clk, .sys_rst, .clk_en, .enable_cmd, .holding_torque_ok, .enc_abs_pos,
  .brake_release_out_q, .power_stage_en_q, .motion_enable_q, .ready_q, .settings_q,
  .dir_ccw_active_q, .motor_speed_q, .abs_pos_q, .cw_limit_hit_q, .ccw_limit_hit_q
);

/* File: testbench/hbd_brake_amp.sv */
// Behavioural brake amplifier driven by the brake release output.
// Assumes power_up is high while its supply comes up.
module hbd_brake_amp
#(
  parameter int unsigned RED_DLY = 8
)
(
  input  wire logic sys_clk,
  input  wire logic power_up,
  input  wire logic volt_reduce_sel,
  input  wire logic brake_ctrl,
  output logic      coil_powered,
  output logic      coil_reduced,
  output logic      released_led
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned hold_cnt;

  always @(posedge sys_clk)
  begin
    if (power_up)
    begin
      coil_powered <= 1'b0;
      coil_reduced <= 1'b0;
      released_led <= 1'b0;
      hold_cnt     <= 0;
    end
    else
    begin
      coil_powered <= brake_ctrl;
      released_led <= brake_ctrl;
      hold_cnt     <= brake_ctrl ? hold_cnt + 1 : 0;
      // Lower hold voltage once pulled in, to keep the coil cool
      coil_reduced <= brake_ctrl && volt_reduce_sel && (hold_cnt >= RED_DLY);
    end
  end
endmodule : hbd_brake_amp

/* File: testbench/hbd_top_tb.sv */
// Self-checking bench for brake sequencing, parameter port and direction mapping.
// Assumes the checker is bound to hbd_top; ms_tick is sped up to one per 4 clocks.
`include "hbd_map.svh"

module hbd_top_tb
  import hbd_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed
  {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [15:0] wdata;
    logic        err;
    logic [15:0] rdata;
  } hbd_row_s;
  logic sys_clk = 1'b0, sys_rst = 1'b1, ms_tick = 1'b0, enable_cmd = 1'b0;
  logic holding_torque_ok = 1'b0, nv_restore = 1'b0, clk_en = 1'b1;
  logic positive_limit_in_n = 1'b1, negative_limit_in_n = 1'b1;
  hbd_settings_s nv_settings = '0, settings_q;
  hbd_par_req_s  par_req = '0;
  logic signed [15:0] speed_cmd = '0, motor_speed_q;
  logic signed [31:0] enc_abs_pos = '0, eval_act_pos = '0, abs_pos_q, act_pos_q;
  logic brake_release_out_q, power_stage_en_q, motion_enable_q, ready_q, par_ack_q;
  logic par_err_q, dir_ccw_active_q, cw_limit_hit_q, ccw_limit_hit_q, coil_powered;
  logic [15:0] par_rdata_q;
  logic [1:0]  ph = '0;
  int err_count = 0, num_checks = 0, cycles = 0, n, i;
  hbd_row_s rows [0:9] = '{
    '{1'b1, 1'b0, 12'h50E, 16'h0002, 1'b0, 16'h0000},
    '{1'b0, 1'b1, 12'h50E, 16'h0000, 1'b0, 16'h0002},
    '{1'b1, 1'b0, 12'h510, 16'h03E8, 1'b0, 16'h0000},
    '{1'b1, 1'b0, 12'h510, 16'h03E9, 1'b1, 16'h0000},
    '{1'b0, 1'b1, 12'h510, 16'h0000, 1'b0, 16'h03E8},
    '{1'b1, 1'b0, 12'h510, 16'h0002, 1'b0, 16'h0000},
    '{1'b1, 1'b0, 12'h618, 16'h0001, 1'b0, 16'h0000},
    '{1'b0, 1'b1, 12'h618, 16'h0000, 1'b0, 16'h0001},
    '{1'b1, 1'b0, 12'h618, 16'h0002, 1'b1, 16'h0000},
    '{1'b0, 1'b1, 12'h600, 16'h0000, 1'b1, 16'h0000}};

  hbd_top u_hbd_top
  (
    .sys_clk, .sys_rst, .clk_en, .ms_tick, .enable_cmd, .holding_torque_ok,
    .nv_restore, .nv_settings, .par_req, .positive_limit_in_n, .negative_limit_in_n,
    .speed_cmd, .enc_abs_pos, .eval_act_pos, .brake_release_out_q, .power_stage_en_q,
    .motion_enable_q, .ready_q, .par_ack_q, .par_err_q, .par_rdata_q, .settings_q,
    .dir_ccw_active_q, .motor_speed_q, .abs_pos_q, .act_pos_q, .cw_limit_hit_q,
    .ccw_limit_hit_q
  );
  hbd_brake_amp u_hbd_brake_amp
  (
    .sys_clk, .power_up(sys_rst), .volt_reduce_sel(1'b1), .brake_ctrl(brake_release_out_q),
    .coil_powered, .coil_reduced(), .released_led()
  );

  initial
  begin
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    ph <= ph + 2'b01;
    ms_tick <= #1 (ph == 2'b11);
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  // Wide enough for the 64-bit position pair, so no flag bit is cut off the top
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : cyc

  // Strobe stays up into the next call so back-to-back rows never double-drive it
  task automatic par(input hbd_row_s r);
    par_req = '{r.wr, r.rd, r.addr, r.wdata};
    cyc(1);
    chk({par_ack_q, par_err_q}, {1'b1, r.err});
    if (r.rd)
      chk(par_rdata_q, r.rdata);
  endtask : par

  // Counts ms ticks until the watched level reaches its target
  task automatic tick_wait(input logic pse);
    n = 0;
    for (i = 0; i < 40 && (pse ? power_stage_en_q : !motion_enable_q) !== 1'b0; i++)
    begin
      @(posedge sys_clk);
      n += ms_tick;
      #1;
    end
  endtask : tick_wait

  task automatic boot(input hbd_settings_s s);
    sys_rst = 1'b1;
    cyc(4);
    sys_rst = 1'b0;
    chk({brake_release_out_q, settings_q}, 49'h0);
    nv_settings = s;
    nv_restore = 1'b1;
    cyc(1);
    nv_restore = 1'b0;
    chk({ready_q, settings_q}, {1'b1, s});
  endtask : boot

  initial
  begin
    boot('0);
    foreach (rows[k])
      par(rows[k]);
    par_req = '0;
    enc_abs_pos = 32'h00000064;
    eval_act_pos = 32'h000000C8;
    speed_cmd = 16'h0005;
    cyc(2);
    chk({dir_ccw_active_q, abs_pos_q}, 33'h000000064);
    chk($unsigned(motor_speed_q), 16'h0000);
    enable_cmd = 1'b1;
    cyc(1);
    chk({power_stage_en_q, brake_release_out_q}, 2'b10);
    holding_torque_ok = 1'b1;
    cyc(1);
    chk({brake_release_out_q, motion_enable_q}, 2'b10);
    tick_wait(1'b0);
    chk(n, 2);
    // Speed output follows motion enable by one registered cycle
    cyc(1);
    chk({coil_powered, motor_speed_q}, 17'h10005);
    positive_limit_in_n = 1'b0;
    cyc(6);
    chk({cw_limit_hit_q, motor_speed_q}, 17'h10000);
    speed_cmd = 16'hFFFB;
    positive_limit_in_n = 1'b1;
    negative_limit_in_n = 1'b0;
    cyc(6);
    chk({ccw_limit_hit_q, motor_speed_q}, 17'h10000);
    negative_limit_in_n = 1'b1;
    cyc(6);
    chk($unsigned(motor_speed_q), 16'hFFFB);
    enable_cmd = 1'b0;
    cyc(1);
    chk({brake_release_out_q, motion_enable_q, power_stage_en_q}, 3'b001);
    tick_wait(1'b1);
    chk(n, 2);
    holding_torque_ok = 1'b0;
    cyc(2);
    boot('{16'h0000, 16'h0000, 16'h0001});
    chk(dir_ccw_active_q, 1'b1);
    cyc(1);
    chk({abs_pos_q, act_pos_q}, 64'hFFFFFF9C_FFFFFF38);
    // Low clock enable must hold every output, a pending enable included
    clk_en = 1'b0;
    enable_cmd = 1'b1;
    enc_abs_pos = 32'h00000010;
    cyc(3);
    chk({power_stage_en_q, abs_pos_q}, 33'h0FFFFFF9C);
    clk_en = 1'b1;
    cyc(1);
    chk({power_stage_en_q, abs_pos_q}, 33'h1FFFFFFF0);
    holding_torque_ok = 1'b1;
    cyc(1);
    chk({brake_release_out_q, motion_enable_q}, 2'b11);
    enable_cmd = 1'b0;
    cyc(1);
    chk({brake_release_out_q, power_stage_en_q}, 2'b00);
    final_report();
  end
endmodule : hbd_top_tb
